// ---- src/nor_flash_core.sv ----
// Overview of operation
// - after reset the part reads in asynchronous mode until read_config_reg is rewritten.
// - burst reads start only once read_config_reg selects them, and then follow the host clock.
// - a wait output tells the host when burst data is not yet valid.
// - an accepted program or erase is run to the end by the write_engine alone.
// - status_reg shows completion and any program or erase error.
// - one erase clears exactly one 32 KByte parameter block or 128 KByte main block.
// - an erase can be suspended to read or program another block, then resumed.
// - a program can be suspended to read other locations, then resumed.
// - programming works on one 16-bit word at a time.
// - block lock and unlock take effect with no added latency.
// - parameter blocks sit at the top addresses of a top part, the bottom of a bottom part.
// - the dual-die part shares one chip enable; the top bit picks the array half and block, and both dies share one command state, status_reg and engine.
// - a low die-select bit picks the lower-parameter die and a high one the upper-parameter die.
module nor_flash_core
  import nor_flash_pkg::*;
#(
  parameter bit DUAL_DIE = 1'b1,
  parameter bit TOP_PARAM = 1'b0,
  parameter int MEM_AW = 16,
  parameter int PROG_CYCLES = 8
) (
  input logic i_clk,
  input logic i_rst_b,
  input logic i_burst_clk,
  input logic i_ce_n,
  input logic i_oe_n,
  input logic i_we_n,
  input logic i_adv_n,
  input logic [nor_flash_pkg::ADDR_W-1:0] i_addr,
  input logic [nor_flash_pkg::DATA_W-1:0] i_dq,
  output logic [nor_flash_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_wait
);
  import nor_flash_pkg::*;

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int WALK_W = MEM_AW - 1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] c1, c2, c3, fc;
    logic [ADDR_W-1:0] a1, a2, a3, fa;
    logic [DATA_W-1:0] d1, d2, d3, fd;
    logic r1, r2, r3, fr, req_seen, ack;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] read_config_reg;
    rmode_t mode;
    cfe_t cfe;
    eng_t eng;
    logic psusp, esusp, perr, eerr, lerr;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] pa, ea;
    logic [DATA_W-1:0] pd;
    logic [WALK_W-1:0] w;
    logic [2**ID_W-1:0] lock;
    logic [DATA_W-1:0] dout;
    logic oe;
  } core_t;

  typedef struct packed {
    logic m1, m2, m3, fm;
    logic k1, k2, k3, fk, ack_seen, req;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic oe, wt;
    link_st_t st;
  } link_t;

  core_t c, n;
  link_t l, nl;
  logic [DATA_W-1:0] mem [2**MEM_AW];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;
  logic [7:0] sr;
  logic we_rise, run_p, run_e, can_prog, prog_go, rcr_wr, lock_op, lock_val;
  logic [ADDR_W-1:0] erase_addr;
  logic [ID_W-1:0] lock_id;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] agree(input logic [ADDR_W-1:0] s2,
                                              input logic [ADDR_W-1:0] s3,
                                              input logic [ADDR_W-1:0] f);
    agree = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & f);
  endfunction

  function automatic logic [MEM_AW-1:0] mem_idx(input logic [ADDR_W-1:0] a);
    mem_idx = DUAL_DIE ? {a[ADDR_W-1], a[MEM_AW-2:0]} : a[MEM_AW-1:0];
  endfunction

  function automatic logic [ID_W-1:0] blk_id(input logic [ADDR_W-1:0] a);
    logic die;
    logic top;
    logic par;
    logic [ID_W-3:0] hi;
    die = DUAL_DIE ? a[ADDR_W-1] : 1'b0;
    top = DUAL_DIE ? die : TOP_PARAM;
    hi = a[DIE_AW-1:MAIN_BITS];
    par = top ? (&hi) : (~|hi);
    blk_id = par ? {die, 1'b1, {(ID_W-2-PIX_W){1'b0}}, a[MAIN_BITS-1:PARAM_BITS]}
                 : {die, 1'b0, hi};
  endfunction

  // ----------------------------------------------------------------
  // core domain: pins, command front end, write engine
  // ----------------------------------------------------------------
  always_comb begin
    n = c;
    mem_we = 1'b0;
    mem_wa = mem_idx(c.pa);
    mem_wd = c.pd;
    prog_go = 1'b0;
    rcr_wr = 1'b0;
    lock_op = 1'b0;
    lock_val = 1'b0;
    lock_id = blk_id(c.fa);
    erase_addr = {c.ea[ADDR_W-1:WALK_W], c.w};
    n.c1 = {i_ce_n, i_we_n, i_oe_n};
    n.c2 = c.c1;
    n.c3 = c.c2;
    n.fc = 3'(agree(ADDR_W'(c.c2), ADDR_W'(c.c3), ADDR_W'(c.fc)));
    n.a1 = i_addr;
    n.a2 = c.a1;
    n.a3 = c.a2;
    n.fa = agree(c.a2, c.a3, c.fa);
    n.d1 = i_dq;
    n.d2 = c.d1;
    n.d3 = c.d2;
    n.fd = DATA_W'(agree(ADDR_W'(c.d2), ADDR_W'(c.d3), ADDR_W'(c.fd)));
    n.r1 = l.req;
    n.r2 = c.r1;
    n.r3 = c.r2;
    n.fr = (c.r2 == c.r3) ? c.r2 : c.fr;
    run_p = (c.eng == ENG_PROG) && !c.psusp;
    run_e = (c.eng == ENG_ERASE) && !c.esusp;
    can_prog = (c.eng == ENG_READY) || ((c.eng == ENG_ERASE) && c.esusp && !c.psusp);
    sr = '0;
    sr[SR_READY] = !(run_p || run_e);
    sr[SR_ESUSP] = c.esusp;
    sr[SR_EERR] = c.eerr;
    sr[SR_PERR] = c.perr;
    sr[SR_PSUSP] = c.psusp;
    sr[SR_LOCKERR] = c.lerr;
    we_rise = !c.fc[PIN_CE] && !c.fc[PIN_WE] && n.fc[PIN_WE];
    if (we_rise) begin
      n.cfe = CFE_NONE;
      unique case (c.cfe)
        CFE_PROG: begin
          n.mode = RM_STATUS;
          if (can_prog) begin
            if (c.lock[lock_id] || (c.esusp && lock_id == blk_id(c.ea))) begin
              n.perr = 1'b1;
              n.lerr = c.lock[lock_id];
            end else begin
              prog_go = 1'b1;
              n.pa = c.fa;
              n.pd = c.fd;
              n.cnt = CNT_W'(PROG_CYCLES - 1);
              n.eng = ENG_PROG;
            end
          end
        end
        CFE_ERASE: begin
          n.mode = RM_STATUS;
          if (c.fd[7:0] == CMD_CONFIRM && c.eng == ENG_READY) begin
            if (c.lock[lock_id]) begin
              n.eerr = 1'b1;
              n.lerr = 1'b1;
            end else begin
              n.ea = c.fa;
              n.w = '0;
              n.eng = ENG_ERASE;
            end
          end else begin
            n.eerr = 1'b1;
          end
        end
        CFE_LOCK: begin
          if (c.fd[7:0] == CMD_LOCK || c.fd[7:0] == CMD_UNLOCK) begin
            lock_op = 1'b1;
            lock_val = (c.fd[7:0] == CMD_LOCK);
            n.lock[lock_id] = lock_val;
          end
        end
        CFE_RCR: begin
          rcr_wr = 1'b1;
          n.read_config_reg = c.fd;
        end
        CFE_NONE: begin
          unique case (c.fd[7:0])
            CMD_READ_ARRAY: n.mode = RM_ARRAY;
            CMD_READ_STATUS: n.mode = RM_STATUS;
            CMD_CLEAR_STATUS: begin
              n.perr = 1'b0;
              n.eerr = 1'b0;
              n.lerr = 1'b0;
            end
            CMD_PROGRAM: n.cfe = CFE_PROG;
            CMD_ERASE: n.cfe = CFE_ERASE;
            CMD_LOCK_SETUP: n.cfe = CFE_LOCK;
            CMD_SET_RCR: n.cfe = CFE_RCR;
            CMD_SUSPEND: begin
              n.mode = RM_STATUS;
              if (run_p) n.psusp = 1'b1;
              if (run_e) n.esusp = 1'b1;
            end
            CMD_CONFIRM: begin
              if (c.psusp) n.psusp = 1'b0;
              else if (c.esusp && c.eng == ENG_ERASE) n.esusp = 1'b0;
            end
            default: ;
          endcase
        end
      endcase
    end
    if (run_p) begin
      if (c.cnt == '0) begin
        mem_we = 1'b1;
        mem_wd = mem[mem_idx(c.pa)] & c.pd;
        n.eng = c.esusp ? ENG_ERASE : ENG_READY;
      end else begin
        n.cnt = c.cnt - 1'b1;
      end
    end
    if (run_e) begin
      if (blk_id(erase_addr) == blk_id(c.ea)) begin
        mem_we = 1'b1;
        mem_wa = mem_idx(erase_addr);
        mem_wd = ERASED_WORD;
      end
      if (&c.w) n.eng = ENG_READY;
      else n.w = c.w + 1'b1;
    end
    if (c.fr != c.req_seen) begin
      n.req_seen = c.fr;
      n.rd = mem[mem_idx(l.addr)];
      n.ack = ~c.ack;
    end
    n.dout = (c.mode == RM_STATUS) ? {8'h00, sr} : mem[mem_idx(c.fa)];
    n.oe = !c.fc[PIN_CE] && !c.fc[PIN_OE];
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c <= '0;
      c.c1 <= 3'h7;
      c.c2 <= 3'h7;
      c.c3 <= 3'h7;
      c.fc <= 3'h7;
      c.read_config_reg <= RCR_RESET;
      c.mode <= RM_ARRAY;
      c.cfe <= CFE_NONE;
      c.eng <= ENG_READY;
    end else begin
      c <= n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------------------------------
  // link domain: burst reads on the host clock
  // ----------------------------------------------------------------
  always_comb begin
    nl = l;
    nl.m1 = ~c.read_config_reg[RCR_ASYNC_BIT];
    nl.m2 = l.m1;
    nl.m3 = l.m2;
    nl.fm = (l.m2 == l.m3) ? l.m2 : l.fm;
    nl.k1 = c.ack;
    nl.k2 = l.k1;
    nl.k3 = l.k2;
    nl.fk = (l.k2 == l.k3) ? l.k2 : l.fk;
    nl.oe = l.fm && !i_ce_n && !i_oe_n;
    if (!l.fm || i_ce_n) begin
      nl.st = L_IDLE;
      nl.wt = 1'b0;
    end else if (!i_adv_n) begin
      nl.addr = i_addr;
      nl.req = ~l.req;
      nl.wt = 1'b1;
      nl.st = L_REQ;
    end else begin
      unique case (l.st)
        L_IDLE: ;
        L_REQ: begin
          if (l.fk != l.ack_seen) begin
            nl.ack_seen = l.fk;
            nl.dq = c.rd;
            nl.wt = 1'b0;
            nl.st = L_OUT;
          end
        end
        L_OUT: begin
          nl.addr = l.addr + 1'b1;
          nl.req = ~l.req;
          nl.wt = 1'b1;
          nl.st = L_REQ;
        end
      endcase
    end
  end

  always_ff @(posedge i_burst_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      l <= '0;
      l.st <= L_IDLE;
    end else begin
      l <= nl;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign o_dq = c.read_config_reg[RCR_ASYNC_BIT] ? c.dout : l.dq;
  assign o_dq_oe = c.read_config_reg[RCR_ASYNC_BIT] ? c.oe : l.oe;
  assign o_wait = l.wt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_prog_go;
    prog_go;
  endsequence

  sequence s_prog_busy;
    (c.eng == ENG_PROG) && !sr[SR_READY];
  endsequence

  chk_async_default: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    c.read_config_reg[RCR_ASYNC_BIT] && !rcr_wr |=> c.read_config_reg[RCR_ASYNC_BIT])
    else $error("read mode left asynchronous without a config write");

  chk_sync_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(c.read_config_reg[RCR_ASYNC_BIT]) |-> $past(rcr_wr))
    else $error("burst mode entered without a config write");

  chk_wait_start: assert property (@(posedge i_burst_clk) disable iff (!i_rst_b)
    l.fm && !i_ce_n && !i_adv_n |=> o_wait ##0 l.st == L_REQ)
    else $error("wait not raised at burst start");

  chk_prog_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_prog_go |=> s_prog_busy ##1 (c.eng == ENG_PROG))
    else $error("accepted program not running");

  chk_prog_done: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    run_p && c.cnt == '0 |=> sr[SR_READY])
    else $error("status not ready after program");

  chk_prog_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    run_p && c.cnt == '0 |-> mem_we && mem_wa == mem_idx(c.pa) && mem_wd == (mem[mem_idx(c.pa)] & c.pd))
    else $error("program word not written");

  chk_erase_block: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    mem_we && run_e |-> blk_id(erase_addr) == blk_id(c.ea) && mem_wd == ERASED_WORD)
    else $error("erase wrote outside its block");

  chk_erase_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (c.esusp && c.eng == ENG_ERASE) [*2] |-> $stable(c.w) && !mem_we)
    else $error("suspended erase kept walking");

  chk_prog_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (c.psusp && c.eng == ENG_PROG) [*2] |-> $stable(c.cnt) && sr[SR_READY])
    else $error("suspended program kept counting");

  chk_lock_now: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    lock_op |=> c.lock[$past(lock_id)] == $past(lock_val))
    else $error("lock state not updated at once");

endmodule

// ---- src/nor_flash_pkg.sv ----
package nor_flash_pkg;

  // ----------------------------------------------------------------
  // bus and array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int DIE_AW = 24;
  localparam int MAIN_KBYTE = 128;
  localparam int PARAM_KBYTE = 32;
  localparam int MAIN_BITS = $clog2(MAIN_KBYTE * 1024 / 2);
  localparam int PARAM_BITS = $clog2(PARAM_KBYTE * 1024 / 2);
  localparam int PIX_W = MAIN_BITS - PARAM_BITS;
  localparam int ID_W = DIE_AW - MAIN_BITS + 2;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // ----------------------------------------------------------------
  // control pin bundle positions
  // ----------------------------------------------------------------
  localparam int PIN_CE = 2;
  localparam int PIN_WE = 1;
  localparam int PIN_OE = 0;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_UNLOCK = 8'hD0;
  localparam logic [7:0] CMD_SET_RCR = 8'h03;

  // ----------------------------------------------------------------
  // status_reg and read_config_reg layout
  // ----------------------------------------------------------------
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 4;
  localparam int SR_PSUSP = 2;
  localparam int SR_LOCKERR = 1;
  localparam int RCR_ASYNC_BIT = 15;
  localparam logic [DATA_W-1:0] RCR_RESET = 16'h8000;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ENG_READY = 3'h1,
    ENG_PROG = 3'h2,
    ENG_ERASE = 3'h4
  } eng_t;

  typedef enum logic [4:0] {
    CFE_NONE = 5'h01,
    CFE_PROG = 5'h02,
    CFE_ERASE = 5'h04,
    CFE_LOCK = 5'h08,
    CFE_RCR = 5'h10
  } cfe_t;

  typedef enum logic [1:0] {
    RM_ARRAY = 2'h1,
    RM_STATUS = 2'h2
  } rmode_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'h1,
    L_REQ = 3'h2,
    L_OUT = 3'h4
  } link_st_t;

endpackage

// ---- tb/nor_flash_host.sv ----
module nor_flash_host
  import nor_flash_pkg::*;
(
  input wire logic i_clk,
  input wire logic [nor_flash_pkg::DATA_W-1:0] i_dq,
  input wire logic i_wait,
  input wire logic i_dev_oe,
  output logic o_bclk,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_adv_n,
  output logic [nor_flash_pkg::ADDR_W-1:0] o_addr,
  output logic [nor_flash_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_bclk = 1'b0;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
    o_adv_n = 1'b1;
    o_addr = '0;
    o_dq = '0;
    o_dq_oe = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      #7.5 o_bclk = 1'b1;
      #7.5 o_bclk = 1'b0;
    end
  endtask

  // -------------------------------------------------------------
  // command write, held well past the three-stage sync
  // -------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_dq <= v;
    o_dq_oe <= 1'b1;
    o_ce_n <= 1'b0;
    step(6);
    o_we_n <= 1'b0;
    step(6);
    o_we_n <= 1'b1;
    step(6);
    o_ce_n <= 1'b1;
    o_dq_oe <= 1'b0;
    step(6);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v, output logic oe);
    @(posedge i_clk);
    o_addr <= a;
    o_ce_n <= 1'b0;
    o_oe_n <= 1'b0;
    step(8);
    #1;
    v = i_dq;
    oe = i_dev_oe;
    @(posedge i_clk);
    o_ce_n <= 1'b1;
    o_oe_n <= 1'b1;
    step(6);
  endtask

  // -------------------------------------------------------------
  // two-word burst; the burst clock runs inside the frame and for two clocks after it
  // -------------------------------------------------------------
  task automatic burst(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] w [2],
                       output logic saw);
    int got;
    logic seen;
    got = 0;
    seen = 1'b0;
    saw = 1'b0;
    @(posedge i_clk);
    o_addr <= a;
    o_ce_n <= 1'b0;
    o_oe_n <= 1'b0;
    #1.3;
    // clocks inside the frame carry the read mode into the burst side
    pulse(4);
    o_adv_n <= 1'b0;
    for (int k = 0; k < 60 && got < 2; k++) begin
      pulse(1);
      o_adv_n <= 1'b1;
      if (i_wait === 1'b1) begin
        seen = 1'b1;
        saw = 1'b1;
      end else if (seen) begin
        w[got] = i_dq;
        got++;
        seen = 1'b0;
      end
    end
    @(posedge i_clk);
    o_ce_n <= 1'b1;
    o_oe_n <= 1'b1;
    // closing clocks let the burst side see the frame end and release dq
    #1.3;
    pulse(2);
    step(6);
  endtask
endmodule

// ---- tb/nor_flash_host_interface_overview_bench.sv ----
module nor_flash_host_interface_overview_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import nor_flash_pkg::*;

  localparam logic [ADDR_W-1:0] A0 = 25'h0000123;
  localparam logic [ADDR_W-1:0] A1 = 25'h1000123;
  localparam int LIMIT = 80000;

  logic i_clk;
  logic i_rst_b;
  logic bclk, ce_n, oe_n, we_n, adv_n, host_oe, dev_oe, wait_w, oe, saw;
  logic [DATA_W-1:0] host_dq, dev_dq, dq_w, d;
  logic [DATA_W-1:0] w [2];
  logic [ADDR_W-1:0] addr;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  // released bus shows the inverse of the host's last value
  assign dq_w = host_oe ? host_dq : (dev_oe ? dev_dq : ~host_dq);

  nor_flash_core #(.DUAL_DIE(1'b1), .TOP_PARAM(1'b0), .MEM_AW(15), .PROG_CYCLES(64))
    nor_flash_core_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_burst_clk(bclk),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_adv_n(adv_n), .i_addr(addr),
    .i_dq(dq_w), .o_dq(dev_dq), .o_dq_oe(dev_oe), .o_wait(wait_w));

  nor_flash_host nor_flash_host_inst (.i_clk(i_clk), .i_dq(dq_w), .i_wait(wait_w),
    .i_dev_oe(dev_oe),
    .o_bclk(bclk), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_adv_n(adv_n),
    .o_addr(addr), .o_dq(host_dq), .o_dq_oe(host_oe));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // -------------------------------------------------------------
  // checking and reporting
  // -------------------------------------------------------------
  task automatic chk_word(input string what, input logic [DATA_W-1:0] exp,
                          input logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("unexpected cycle count: expected below %0d seen %0d", LIMIT, cycles);
      give_verdict();
    end
  end

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    nor_flash_host_inst.wr(a, v);
  endtask

  task automatic get(input logic [ADDR_W-1:0] a);
    nor_flash_host_inst.rd(a, d, oe);
  endtask

  task automatic poll_ready();
    int k;
    k = 0;
    put(A0, {8'h00, CMD_READ_STATUS});
    do begin
      get(A0);
      k++;
    end while (d[SR_READY] !== 1'b1 && k < 2000);
    chk_bit("ready flag", 1'b1, d[SR_READY]);
  endtask

  task automatic status_is(input logic [DATA_W-1:0] exp);
    put(A0, {8'h00, CMD_READ_STATUS});
    get(A0);
    chk_word("status word", exp, d);
  endtask

  task automatic array_is(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    put(A0, {8'h00, CMD_READ_ARRAY});
    get(a);
    chk_word("array word", exp, d);
    chk_bit("array drive", 1'b1, oe);
  endtask

  task automatic erase(input logic [ADDR_W-1:0] a);
    put(a, {8'h00, CMD_ERASE});
    put(a, {8'h00, CMD_CONFIRM});
  endtask

  task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    put(a, {8'h00, CMD_PROGRAM});
    put(a, v);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    chk_bit("dq enable after reset", 1'b0, dev_oe);
    chk_bit("wait after reset", 1'b0, wait_w);
    status_is(16'h0080);
    chk_bit("async output enable", 1'b1, dev_oe === 1'b0);
    $display("test reset done");
  endtask

  task automatic t_erase_prog();
    erase(A0);
    poll_ready();
    status_is(16'h0080);
    prog(A0, 16'h1234);
    poll_ready();
    array_is(A0, 16'h1234);
    array_is(A0 + 25'h1, 16'hFFFF);
    erase(A1);
    poll_ready();
    array_is(A0, 16'h1234);
    array_is(A1, 16'hFFFF);
    prog(A1, 16'hABCD);
    poll_ready();
    array_is(A1, 16'hABCD);
    array_is(A0, 16'h1234);
    $display("test erase and program done");
  endtask

  task automatic t_errors();
    put(A0, {8'h00, CMD_ERASE});
    put(A0, {8'h00, CMD_READ_ARRAY});
    status_is(16'h00A0);
    put(A0, {8'h00, CMD_CLEAR_STATUS});
    status_is(16'h0080);
    put(A0, {8'h00, CMD_LOCK_SETUP});
    put(A0, {8'h00, CMD_LOCK});
    prog(A0, 16'h0000);
    status_is(16'h0092);
    put(A0, {8'h00, CMD_CLEAR_STATUS});
    put(A0, {8'h00, CMD_LOCK_SETUP});
    put(A0, {8'h00, CMD_UNLOCK});
    prog(A0, 16'h1200);
    poll_ready();
    array_is(A0, 16'h1200);
    $display("test errors and locking done");
  endtask

  task automatic t_suspend();
    erase(A1);
    repeat (100) @(posedge i_clk);
    put(A0, {8'h00, CMD_SUSPEND});
    poll_ready();
    status_is(16'h00C0);
    array_is(A0, 16'h1200);
    prog(A0 + 25'h2, 16'h0F0F);
    poll_ready();
    status_is(16'h00C0);
    array_is(A0 + 25'h2, 16'h0F0F);
    put(A0, {8'h00, CMD_CONFIRM});
    poll_ready();
    status_is(16'h0080);
    array_is(A1, 16'hFFFF);
    $display("test erase suspend done");
  endtask

  task automatic t_prog_suspend();
    prog(A1 + 25'h1, 16'h5A5A);
    put(A0, {8'h00, CMD_SUSPEND});
    poll_ready();
    status_is(16'h0084);
    array_is(A0, 16'h1200);
    put(A0, {8'h00, CMD_CONFIRM});
    poll_ready();
    status_is(16'h0080);
    array_is(A1 + 25'h1, 16'h5A5A);
    $display("test program suspend done");
  endtask

  task automatic t_burst();
    put(A0, {8'h00, CMD_SET_RCR});
    put(A0, 16'h0000);
    repeat (10) @(posedge i_clk);
    nor_flash_host_inst.burst(A0, w, saw);
    chk_bit("wait seen", 1'b1, saw);
    chk_word("burst word 0", 16'h1200, w[0]);
    chk_word("burst word 1", 16'hFFFF, w[1]);
    $display("test burst done");
  endtask

  initial begin
    i_rst_b = 1'b1;
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_erase_prog();
    t_errors();
    t_suspend();
    t_prog_suspend();
    t_burst();
    give_verdict();
  end
endmodule
